// *** design/pus_seq.sv ***
// Notes on behaviour
// - internal reset is held until bias and 1v8 rails are good and the oscillator is stable.
// - leaving reset starts a read of the whole nonvolatile store; words 0 to 2 load the working registers.
// - after the load, bus writes to configuration are taken regardless of enable.
// - by default conversion runs only with enable, input above uvlo, load done and address read.
// - software start options, when configured, replace the pin-based enable gating.
// - a 7-bit i2c base address of zero makes i2c ignore all traffic, pmbus unaffected.
// - a 7-bit pmbus base address of zero makes pmbus ignore all traffic, i2c unaffected.
// - bus addresses are a strapped offset (16 values) added to the bases loaded from the nonvolatile store.
// - the strap resistor is measured by a 10 bit converter during initialisation.
// - after initialisation both buses answer at base plus offset.
// - the offset-disable bit makes both buses answer at the base addresses only.
`timescale 1ns/100ps
module pus_seq
(
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic              bias_good_i,
   input  wire logic              core_supply_1v8_good_i,
   input  wire logic              osc_stable_i,
   input  wire logic              enable_i,
   input  wire logic              vin_uvlo_ok_i,
   output      logic              adc_start_o,
   input  wire logic              adc_done_i,
   input  wire logic [9:0]        adc_code_i,
   input  wire logic              cfg_wr_i,
   input  wire logic [1:0]        cfg_sel_i,
   input  wire logic [6:0]        cfg_wdata_i,
   input  wire logic              nv_prog_i,
   input  wire logic [3:0]        nv_prog_addr_i,
   input  wire logic [15:0]       nv_prog_data_i,
   output      logic              por_n_o,
   output      logic              load_done_o,
   output      logic              addr_read_o,
   output      logic              convert_o,
   output      logic              i2c_active_o,
   output      logic              pmbus_active_o,
   output      logic [6:0]        i2c_slave_id_o,
   output      logic [6:0]        pmbus_slave_id_o,
   output      logic [6:0]        i2c_base_slave_id_o,
   output      logic [6:0]        pmbus_base_slave_id_o,
   output      logic [2:0]        ctrl_o
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         s1_reg <= 5'h00;
         s2_reg <= 5'h00;
      end
      else
      begin
         s1_reg <= {bias_good_i, core_supply_1v8_good_i, osc_stable_i,
                    enable_i, vin_uvlo_ok_i};
         s2_reg <= s1_reg;
      end
   end
   logic rails_ok;
   logic en_ok;
   logic uv_ok;
   assign rails_ok = s2_reg[4] & s2_reg[3] & s2_reg[2];
   assign en_ok    = s2_reg[1];
   assign uv_ok    = s2_reg[0];

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      ST_POR  = 5'b00001,
      ST_LOAD = 5'b00010,
      ST_ADC  = 5'b00100,
      ST_WAIT = 5'b01000,
      ST_RUN  = 5'b10000
   } pus_state_t;

   pus_state_t state_reg;
   pus_state_t state_next;
   logic [3:0] ld_idx_reg;
   logic       ld_pend_reg;
   logic [3:0] ld_widx_reg;

   pus_nv_if nv ();
   pus_nv_store u_nv
   (
      .clk_i (clk_i),
      .nv    (nv)
   );

   // load walks every word; the read data lags the address by one cycle
   assign nv.rd_en   = (state_reg == ST_LOAD);
   assign nv.rd_addr = ld_idx_reg;
   assign nv.wr_en   = nv_prog_i;
   assign nv.wr_addr = nv_prog_addr_i;
   assign nv.wr_data = nv_prog_data_i;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_POR:  if (rails_ok) state_next = ST_LOAD;
         ST_LOAD: if (ld_pend_reg && ld_widx_reg == pus_pkg::NV_LAST)
                     state_next = ST_ADC;
         ST_ADC:  if (adc_done_i) state_next = ST_WAIT;
         ST_WAIT: state_next = ST_RUN;
         ST_RUN:  state_next = ST_RUN;
      endcase
      // losing a rail drops the part back into power-on reset
      if (!rails_ok)
         state_next = ST_POR;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         state_reg <= ST_POR;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i || state_reg != ST_LOAD)
      begin
         ld_idx_reg  <= 4'h0;
         ld_pend_reg <= 1'b0;
         ld_widx_reg <= 4'h0;
      end
      else
      begin
         if (ld_idx_reg != pus_pkg::NV_LAST)
            ld_idx_reg <= ld_idx_reg + 4'h1;
         ld_pend_reg <= 1'b1;
         ld_widx_reg <= ld_idx_reg;
      end
   end

   assign adc_start_o = (state_reg == ST_ADC);
   assign por_n_o     = (state_reg != ST_POR);

   // ---------------------------------------------------------------
   // working registers
   // ---------------------------------------------------------------
   logic [6:0] i2c_base_slave_id_reg;
   logic [6:0] pmbus_base_slave_id_reg;
   logic [2:0] ctrl_reg;
   logic       load_done_reg;
   logic       addr_read_reg;
   logic [3:0] offset_reg;

   always_ff @(posedge clk_i)
   begin
      if (srst_i || state_reg == ST_POR)
      begin
         i2c_base_slave_id_reg   <= pus_pkg::I2C_BASE_RST;
         pmbus_base_slave_id_reg <= pus_pkg::PMB_BASE_RST;
         ctrl_reg                <= 3'h0;
      end
      else if (state_reg == ST_LOAD && ld_pend_reg)
      begin
         unique case (ld_widx_reg)
            pus_pkg::NV_IDX_I2C:  i2c_base_slave_id_reg   <= nv.rd_data[6:0];
            pus_pkg::NV_IDX_PMB:  pmbus_base_slave_id_reg <= nv.rd_data[6:0];
            pus_pkg::NV_IDX_CTRL: ctrl_reg                <= nv.rd_data[2:0];
            default:              ;
         endcase
      end
      else if (load_done_reg && cfg_wr_i)
      begin
         // taken in any enable state once the load is through
         unique case (cfg_sel_i)
            2'h0:    i2c_base_slave_id_reg   <= cfg_wdata_i;
            2'h1:    pmbus_base_slave_id_reg <= cfg_wdata_i;
            2'h2:    ctrl_reg                <= cfg_wdata_i[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i || state_reg == ST_POR)
         load_done_reg <= 1'b0;
      else if (state_reg == ST_LOAD && ld_pend_reg &&
               ld_widx_reg == pus_pkg::NV_LAST)
         load_done_reg <= 1'b1;
   end

   // strap offset: ten bit code quantised into sixteen bins
   always_ff @(posedge clk_i)
   begin
      if (srst_i || state_reg == ST_POR)
      begin
         offset_reg    <= 4'h0;
         addr_read_reg <= 1'b0;
      end
      else if (state_reg == ST_ADC && adc_done_i)
      begin
         offset_reg    <= adc_code_i[pus_pkg::ADC_W-1 -: pus_pkg::OFF_W];
         addr_read_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // addresses
   // ---------------------------------------------------------------
   logic [6:0] off7;
   assign off7 = ctrl_reg[pus_pkg::CTRL_NOOFF_BIT] ? pus_pkg::ADDR_OFF
                 : {3'h0, offset_reg};
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         i2c_slave_id_o   <= 7'h00;
         pmbus_slave_id_o <= 7'h00;
         i2c_active_o     <= 1'b0;
         pmbus_active_o   <= 1'b0;
      end
      else
      begin
         i2c_slave_id_o   <= i2c_base_slave_id_reg + off7;
         pmbus_slave_id_o <= pmbus_base_slave_id_reg + off7;
         i2c_active_o     <= addr_read_reg &&
                             i2c_base_slave_id_reg != 7'h00;
         pmbus_active_o   <= addr_read_reg &&
                             pmbus_base_slave_id_reg != 7'h00;
      end
   end

   // ---------------------------------------------------------------
   // conversion gating
   // ---------------------------------------------------------------
   logic gate_ok;
   logic start_ok;
   assign gate_ok  = load_done_reg & addr_read_reg;
   assign start_ok = ctrl_reg[pus_pkg::CTRL_SWEN_BIT]
                     ? ctrl_reg[pus_pkg::CTRL_SWON_BIT] & uv_ok
                     : en_ok & uv_ok;
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         convert_o <= 1'b0;
      else
         convert_o <= (state_reg == ST_RUN) && gate_ok && start_ok;
   end

   assign load_done_o           = load_done_reg;
   assign addr_read_o           = addr_read_reg;
   assign i2c_base_slave_id_o   = i2c_base_slave_id_reg;
   assign pmbus_base_slave_id_o = pmbus_base_slave_id_reg;
   assign ctrl_o                = ctrl_reg;
endmodule // pus_seq

// *** design/pus_pkg.sv ***
package pus_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam logic [6:0]  I2C_BASE_RST    = 7'h10;
   localparam logic [6:0]  PMB_BASE_RST    = 7'h40;
   localparam logic [6:0]  ADDR_OFF        = 7'h00;
   localparam int unsigned NV_WORDS        = 16;
   localparam int unsigned NV_AW           = 4;
   localparam int unsigned NV_DW           = 16;
   localparam logic [3:0]  NV_IDX_I2C      = 4'h0;
   localparam logic [3:0]  NV_IDX_PMB      = 4'h1;
   localparam logic [3:0]  NV_IDX_CTRL     = 4'h2;
   localparam logic [3:0]  NV_LAST         = 4'hF;
   localparam int unsigned CTRL_NOOFF_BIT  = 0;
   localparam int unsigned CTRL_SWEN_BIT   = 1;
   localparam int unsigned CTRL_SWON_BIT   = 2;
   localparam int unsigned ADC_W           = 10;
   localparam int unsigned OFF_W           = 4;
   localparam logic [ADC_W-1:0] OFF_STEP   = 10'h040;
   typedef logic [NV_DW-1:0] pus_word_t;
endpackage

// *** design/pus_nv_if.sv ***
`timescale 1ns/100ps
interface pus_nv_if;
   logic                       rd_en;
   logic [pus_pkg::NV_AW-1:0]  rd_addr;
   pus_pkg::pus_word_t         rd_data;
   logic                       wr_en;
   logic [pus_pkg::NV_AW-1:0]  wr_addr;
   pus_pkg::pus_word_t         wr_data;
   modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
                 input rd_data);
   modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
                 output rd_data);
endinterface

// *** design/pus_nv_store.sv ***
`timescale 1ns/100ps
module pus_nv_store
(
   input  wire logic clk_i,
   pus_nv_if.mem     nv
);
   pus_pkg::pus_word_t mem_reg [pus_pkg::NV_WORDS];
   pus_pkg::pus_word_t rd_reg;

   // contents are nonvolatile: no reset, programmed through the write port
   always_ff @(posedge clk_i)
   begin
      if (nv.wr_en)
         mem_reg[nv.wr_addr] <= nv.wr_data;
   end

   always_ff @(posedge clk_i)
   begin
      if (nv.rd_en)
         rd_reg <= mem_reg[nv.rd_addr];
   end

   assign nv.rd_data = rd_reg;
endmodule // pus_nv_store

// *** test/pus_seq_asserts.sv ***
`timescale 1ns/100ps
module pus_seq_asserts
(
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       bias_good_i,
   input wire logic       core_supply_1v8_good_i,
   input wire logic       osc_stable_i,
   input wire logic       enable_i,
   input wire logic       adc_start_o,
   input wire logic       adc_done_i,
   input wire logic [9:0] adc_code_i,
   input wire logic       cfg_wr_i,
   input wire logic [1:0] cfg_sel_i,
   input wire logic [6:0] cfg_wdata_i,
   input wire logic       por_n_o,
   input wire logic       load_done_o,
   input wire logic       addr_read_o,
   input wire logic       convert_o,
   input wire logic       i2c_active_o,
   input wire logic       pmbus_active_o,
   input wire logic [6:0] i2c_slave_id_o,
   input wire logic [6:0] pmbus_slave_id_o,
   input wire logic [6:0] i2c_base_slave_id_o,
   input wire logic [6:0] pmbus_base_slave_id_o,
   input wire logic [2:0] ctrl_o
);
   logic [3:0] off_reg;
   wire logic  rails_ok = bias_good_i & core_supply_1v8_good_i & osc_stable_i;
   // -------------------------------------------
   // internal reset masks everything it clears
   // -------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i || !por_n_o);
   always_ff @(posedge clk_i)
      if (adc_start_o && adc_done_i)
         off_reg <= adc_code_i[9:6];
   sequence s_up; $rose(por_n_o); endsequence
   sequence s_set; addr_read_o && $stable(ctrl_o)
      && $stable(i2c_base_slave_id_o) && $stable(pmbus_base_slave_id_o);
   endsequence
   // own disable: the default one would mask the very state checked here
   property p_por; disable iff (srst_i) (!rails_ok) [*5] |-> !por_n_o;
   endproperty
   property p_load; s_up |-> !load_done_o ##[13:17] $rose(load_done_o);
   endproperty
   property p_adc; $rose(load_done_o) |-> adc_start_o && !addr_read_o;
   endproperty
   property p_wr; cfg_wr_i && load_done_o && cfg_sel_i == 2'h0
      |=> i2c_base_slave_id_o == $past(cfg_wdata_i); endproperty
   property p_gate; convert_o |-> load_done_o && addr_read_o; endproperty
   property p_drop; $fell(enable_i) && !ctrl_o[1] |-> ##[1:5] !convert_o;
   endproperty
   property p_sum; s_set ##0 !ctrl_o[0] |=> i2c_slave_id_o ==
      7'($past(i2c_base_slave_id_o) + 7'(off_reg)) && pmbus_slave_id_o ==
      7'($past(pmbus_base_slave_id_o) + 7'(off_reg)); endproperty
   property p_nooff; s_set ##0 ctrl_o[0]
      |=> i2c_slave_id_o == $past(i2c_base_slave_id_o)
      && pmbus_slave_id_o == $past(pmbus_base_slave_id_o); endproperty
   property p_i2c0; s_set ##0 i2c_base_slave_id_o == 7'h00 |=> !i2c_active_o
      && pmbus_active_o == ($past(pmbus_base_slave_id_o) != 7'h00);
   endproperty
   property p_pmb0; s_set ##0 pmbus_base_slave_id_o == 7'h00
      |=> !pmbus_active_o
      && i2c_active_o == ($past(i2c_base_slave_id_o) != 7'h00); endproperty
   a_por: assert property (p_por) else $error("por left early");
   a_load: assert property (p_load) else $error("load length");
   a_adc: assert property (p_adc) else $error("no strap read");
   a_wr: assert property (p_wr) else $error("cfg write lost");
   a_gate: assert property (p_gate) else $error("early convert");
   a_drop: assert property (p_drop) else $error("convert held");
   a_sum: assert property (p_sum) else $error("bad id sum");
   a_nooff: assert property (p_nooff) else $error("offset used");
   a_i2c0: assert property (p_i2c0) else $error("i2c not off");
   a_pmb0: assert property (p_pmb0) else $error("pmbus not off");
endmodule // pus_seq_asserts
bind pus_seq pus_seq_asserts chk_u (.*);

// *** test/pus_host_model.sv ***
`timescale 1ns/100ps
module pus_host_model
(
   input  wire logic       clk_i,
   input  wire logic       adc_start_i,
   input  wire logic [9:0] strap_code_i,
   output      logic       adc_done_o,
   output      logic [9:0] adc_code_o,
   output      logic       cfg_wr_o,
   output      logic [1:0] cfg_sel_o,
   output      logic [6:0] cfg_wdata_o
);
   logic [2:0] wait_reg = 3'h0;
   initial {adc_done_o, adc_code_o, cfg_wr_o, cfg_sel_o, cfg_wdata_o} = '0;
   // code lines toggle while not valid so a stale sample shows up
   always @(posedge clk_i)
   begin
      wait_reg   <= adc_start_i ? wait_reg + 3'h1 : 3'h0;
      adc_done_o <= adc_start_i && wait_reg == 3'h4;
      adc_code_o <= (adc_start_i && wait_reg == 3'h4) ? strap_code_i
                                                       : ~adc_code_o;
   end
   task automatic cfg_write(input logic [1:0] sel, input logic [6:0] data);
      @(posedge clk_i);
      cfg_wr_o    <= 1'b1;
      cfg_sel_o   <= sel;
      cfg_wdata_o <= data;
      @(posedge clk_i);
      cfg_wr_o    <= 1'b0;
      cfg_wdata_o <= ~data;
   endtask
endmodule // pus_host_model

// *** test/pus_seq_tb_top.sv ***
`timescale 1ns/100ps
module pus_seq_tb_top;
   logic        clk_i = 1'b0, srst_i = 1'b1, nv_prog_i = 1'b0;
   logic        bias_good_i = 1'b0, core_supply_1v8_good_i = 1'b0;
   logic        osc_stable_i = 1'b0, enable_i = 1'b0, vin_uvlo_ok_i = 1'b0;
   logic        adc_start_o, adc_done_i, cfg_wr_i, por_n_o, load_done_o;
   logic        addr_read_o, convert_o, i2c_active_o, pmbus_active_o;
   logic [9:0]  adc_code_i, strap = 10'h3C0;
   logic [1:0]  cfg_sel_i;
   logic [6:0]  cfg_wdata_i, i2c_slave_id_o, pmbus_slave_id_o;
   logic [6:0]  i2c_base_slave_id_o, pmbus_base_slave_id_o;
   logic [3:0]  nv_prog_addr_i = 4'h0;
   logic [15:0] nv_prog_data_i = 16'h0000;
   logic [2:0]  ctrl_o;
   int          miscompares = 0, cmp_count = 0;
   pus_seq dut_u (.*);
   pus_host_model host_u (.clk_i(clk_i), .adc_start_i(adc_start_o),
      .strap_code_i(strap), .adc_done_o(adc_done_i),
      .adc_code_o(adc_code_i), .cfg_wr_o(cfg_wr_i),
      .cfg_sel_o(cfg_sel_i), .cfg_wdata_o(cfg_wdata_i));
   always #50 clk_i = ~clk_i;
   // -------------------------------------------
   // shared tasks
   // -------------------------------------------
   task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic test_done;
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      while (!(k ? addr_read_o : load_done_o) && n < 200)
      begin
         tk(1);
         n++;
      end
      if (n == 200)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: wait timed out", $time);
         test_done;
      end
   endtask
   // rails dropped and raised again, so each call reloads the store
   task automatic power_up(input logic [6:0] ib, pb, input logic [2:0] ct);
      for (int i = 0; i < 16; i++)
      begin
         tk(1);
         nv_prog_i      <= 1'b1;
         nv_prog_addr_i <= 4'(i);
         nv_prog_data_i <= i == 0 ? 16'(ib) : i == 1 ? 16'(pb) :
                           i == 2 ? 16'(ct) : 16'hFFFF;
      end
      tk(1);
      {nv_prog_i, bias_good_i, osc_stable_i, enable_i} <= 4'h0;
      tk(4);
      {bias_good_i, core_supply_1v8_good_i} <= 2'h3;
      tk(8);
      #1 chk(7'(por_n_o), 7'h00);
      tk(1);
      osc_stable_i <= 1'b1;
      host_u.cfg_write(2'h0, 7'h55);
      wait_hi(0);
      #1 chk(i2c_base_slave_id_o, ib);
      chk(pmbus_base_slave_id_o, pb);
      chk(7'(ctrl_o), 7'(ct));
      chk(7'(por_n_o), 7'h01);
      wait_hi(1);
      tk(1);
      {enable_i, vin_uvlo_ok_i} <= 2'h3;
      tk(6);
      #1 chk(7'(convert_o), 7'h01);
      chk(i2c_slave_id_o, ct[0] ? ib : ib + 7'(strap[9:6]));
      chk(pmbus_slave_id_o, ct[0] ? pb : pb + 7'(strap[9:6]));
   endtask
   task automatic s_gate;
      tk(1);
      enable_i <= 1'b0;
      host_u.cfg_write(2'h1, 7'h33);
      tk(6);
      #1 chk(7'(convert_o), 7'h00);
      chk(pmbus_base_slave_id_o, 7'h33);
      chk(pmbus_slave_id_o, 7'h42);
      tk(1);
      enable_i <= 1'b1;
      tk(6);
      #1 chk(7'(convert_o), 7'h01);
      tk(1);
      vin_uvlo_ok_i <= 1'b0;
      tk(6);
      #1 chk(7'(convert_o), 7'h00);
      tk(1);
      vin_uvlo_ok_i <= 1'b1;
   endtask
   task automatic s_zero;
      host_u.cfg_write(2'h0, 7'h00);
      tk(3);
      #1 chk(7'({i2c_active_o, pmbus_active_o}), 7'h01);
      host_u.cfg_write(2'h0, 7'h10);
      host_u.cfg_write(2'h1, 7'h00);
      tk(3);
      #1 chk(7'({i2c_active_o, pmbus_active_o}), 7'h02);
   endtask
   task automatic s_sw;
      host_u.cfg_write(2'h2, 7'h02);
      tk(6);
      #1 chk(7'(convert_o), 7'h00);
      tk(1);
      enable_i <= 1'b0;
      host_u.cfg_write(2'h2, 7'h06);
      tk(6);
      #1 chk(7'(convert_o), 7'h01);
   endtask
   initial
   begin
      tk(5);
      srst_i <= 1'b0;
      power_up(7'h10, 7'h40, 3'h0);
      s_gate;
      s_zero;
      tk(1);
      strap <= 10'h0BF;
      power_up(7'h25, 7'h5A, 3'h1);
      host_u.cfg_write(2'h2, 7'h00);
      tk(3);
      #1 chk(i2c_slave_id_o, 7'h27);
      s_sw;
      test_done;
   end
endmodule // pus_seq_tb_top
